/* design/padc_fifo.v */
// small flop fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module padc_fifo #(
  parameter W = 12,
  parameter DEPTH = 16,
  parameter AW = 4
)(
  // clock and reset
  input wire clk,
  input wire rst,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  localparam [AW:0] FULL_CNT = DEPTH;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != FULL_CNT);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
    if (rst)
    begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule
`default_nettype wire

/* design/padc_map.vh */
// constants for the pipelined converter output port
`ifndef PADC_MAP_VH
`define PADC_MAP_VH
`define PADC_RES_W 12
`define PADC_LATENCY 7
`define PADC_FIFO_DEPTH 16
`define PADC_MSB 11
`define PADC_LSB 0
`define PADC_CODE_MIDSCALE 12'h800
`define PADC_CODE_ZERO 12'h000
`endif

/* design/padc_port.v */
// output side of the pipelined 12-bit converter
// Operation
// R1 - sample taken on each conversion clock rise
// R2 - result appears seven cycles after sampling
// R3 - output disable high floats all outputs
// R4 - shutdown with outputs enabled holds last word
// R5 - results coded in offset binary
// R6 - bit zero lsb, bit eleven msb
// R7 - shutdown high stops conversion, low converts
// R8 - data valid only while disable is low
// R9 - receiver drops seven words after start
`timescale 1ns/1ns
`default_nettype none
`include "padc_map.vh"
module padc_port #(
  parameter W = `PADC_RES_W,
  parameter LATENCY = `PADC_LATENCY,
  parameter DEPTH = `PADC_FIFO_DEPTH
)(
  // clock and reset
  input wire clk,
  input wire rst,
  // quantizer side: signed sample from the analog pipeline
  input wire [W-1:0] sample_twos,
  // pins
  input wire output_disable_n_pin,
  input wire shutdown_request,
  // result bus, two signals per pin
  output reg [W-1:0] conversion_result_bus,
  output reg [W-1:0] conversion_result_oe_n,
  // data tap through the fifo
  output wire tap_valid,
  input wire tap_ready,
  output wire [W-1:0] tap_data,
  output reg tap_overrun
);
  // pin synchronisers
  reg dis_s1_q;
  reg dis_s2_q;
  reg sd_s1_q;
  reg sd_s2_q;
  reg [W-1:0] pipe_q [0:LATENCY-1];
  reg [LATENCY-1:0] vld_q;
  reg [W-1:0] word_d;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [W-1:0] fifo_out_data;
  integer i;

  // signed to offset binary: flip the sign bit
  function [W-1:0] to_offset;
    input [W-1:0] v;
    begin
      to_offset = {~v[W-1], v[W-2:0]}; // [R5]
    end
  endfunction

  always @(posedge clk)
  begin
    dis_s1_q <= output_disable_n_pin;
    dis_s2_q <= dis_s1_q;
    sd_s1_q <= shutdown_request;
    sd_s2_q <= sd_s1_q;
  end

  // pipeline: one stage per clock, stage LATENCY-2 feeds the bus register, which is the output latch
  always @(posedge clk)
  begin
    if (rst)
    begin
      vld_q <= {LATENCY{1'b0}};
      for (i = 0; i < LATENCY; i = i + 1)
        pipe_q[i] <= `PADC_CODE_MIDSCALE;
    end
    else if (!sd_s2_q) // [R7]
    begin
      pipe_q[0] <= to_offset(sample_twos); // [R1] [R5]
      vld_q <= {vld_q[LATENCY-2:0], 1'b1};
      for (i = 1; i < LATENCY; i = i + 1)
        pipe_q[i] <= pipe_q[i-1]; // [R2]
    end
    else
      vld_q <= {LATENCY{1'b0}}; // flushed: first words after wake are junk [R9]
  end

  always @*
  begin
    word_d = conversion_result_bus;
    if (!sd_s2_q)
      word_d = pipe_q[LATENCY-2]; // with the bus flop, seven edges [R2]
  end

  // bus register freezes during shutdown; oe low means driving
  always @(posedge clk)
  begin
    if (rst)
    begin
      conversion_result_bus <= `PADC_CODE_MIDSCALE;
      conversion_result_oe_n <= {W{1'b1}};
      tap_overrun <= 1'b0;
    end
    else
    begin
      conversion_result_bus <= word_d; // [R4] [R6]
      conversion_result_oe_n <= {W{dis_s2_q}}; // [R3] [R8]
      if (!sd_s2_q && vld_q[LATENCY-2] && !fifo_in_ready)
        tap_overrun <= 1'b1; // sticky; stream cannot stall the analog pipe
    end
  end

  padc_fifo #(
    .W(W),
    .DEPTH(DEPTH),
    .AW(4)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(!sd_s2_q && vld_q[LATENCY-2]),
    .in_ready(fifo_in_ready),
    .in_data(pipe_q[LATENCY-2]),
    .out_valid(fifo_out_valid),
    .out_ready(tap_ready),
    .out_data(fifo_out_data)
  );
  assign tap_valid = fifo_out_valid;
  assign tap_data = fifo_out_data;
endmodule
`default_nettype wire

/* testbench/padc_monitor.sv */
// assertions on the converter output port
`timescale 1ns/1ns
`default_nettype none
module padc_monitor (
  // clock, inputs, pins
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] sample_twos,
  input wire logic output_disable_n_pin,
  input wire logic shutdown_request,
  input wire logic [11:0] conversion_result_bus,
  input wire logic [11:0] conversion_result_oe_n
);
  wire [11:0] s = sample_twos;
  wire [11:0] bus = conversion_result_bus;
  wire [11:0] oe = conversion_result_oe_n;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // two edges low cover the pin synchroniser before the capture edge
  sequence settle;
    !shutdown_request[*2];
  endsequence
  // pipe must keep moving until the word reaches the bus
  sequence drain;
    !shutdown_request[*4];
  endsequence
  AST_LAT: assert property (settle ##1 !shutdown_request ##1 drain |-> ##3 bus == ($past(s, 7) ^ 12'h800))
    else $error("latency");
  AST_MSB: assert property (settle ##1 !shutdown_request ##1 drain |-> ##3 bus[11] != $past(s[11], 7))
    else $error("msb");
  AST_ZERO: assert property (settle ##1 (!shutdown_request && s == 12'h800) ##1 drain |-> ##3 bus == 0)
    else $error("zero");
  AST_FULL: assert property (settle ##1 (!shutdown_request && s == 12'h7ff) ##1 drain |-> ##3 &bus)
    else $error("full");
  AST_HOLD: assert property (shutdown_request[*4] |=> $stable(bus)) else $error("hold");
  AST_FLOAT: assert property (output_disable_n_pin[*4] |-> &oe) else $error("float");
  AST_DRIVE: assert property (!output_disable_n_pin[*4] |-> oe == 0) else $error("drive");
  AST_SAME: assert property (&oe || oe == 0) else $error("enables");
endmodule
bind padc_port padc_monitor mon (.clk, .rst, .sample_twos, .output_disable_n_pin, .shutdown_request,
  .conversion_result_bus, .conversion_result_oe_n);
`default_nettype wire

/* testbench/padc_sink.sv */
// far-side capture logic, able to stall
`timescale 1ns/1ns
`default_nettype none
module padc_sink (
  // control
  input wire logic stall,
  // tap handshake
  output logic tap_ready
);
  assign tap_ready = !stall;
endmodule
`default_nettype wire

/* testbench/test_pipelined_adc_output_port.sv */
// testbench for the converter output port
`timescale 1ns/1ns
`default_nettype none
module test_pipelined_adc_output_port;
  logic clk = 0, rst = 1, output_disable_n_pin = 0, shutdown_request = 0, stall = 0;
  logic [11:0] sample_twos = 0, conversion_result_bus, conversion_result_oe_n;
  logic tap_valid, tap_ready, tap_overrun;
  logic [11:0] tap_data;
  int n_mismatch = 0, comparisons = 0;
  always #50 clk = ~clk;
  padc_port dut (.clk, .rst, .sample_twos, .output_disable_n_pin, .shutdown_request, .conversion_result_bus,
    .conversion_result_oe_n, .tap_valid, .tap_ready, .tap_data, .tap_overrun);
  padc_sink sink (.stall, .tap_ready);
  task automatic w(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task t_float;
    output_disable_n_pin = 1;
    w(4);
    chk("oe_n", 12'hfff, conversion_result_oe_n);
    output_disable_n_pin = 0;
    w(4);
    chk("oe_n", 12'h000, conversion_result_oe_n);
    $display("float ends");
  endtask
  task t_stream;
    for (int i = 0; i < 24; i++)
    begin
      sample_twos = 12'h800 + 12'(i) * 12'h111;
      if (i >= 7) chk("bus", 12'(i - 7) * 12'h111, conversion_result_bus);
      w(1);
    end
    $display("stream ends");
  endtask
  task t_hold;
    sample_twos = 12'h123;
    w(10);
    shutdown_request = 1;
    w(3);
    sample_twos = 12'h456;
    w(10);
    chk("hold", 12'h923, conversion_result_bus);
    shutdown_request = 0;
    w(10);
    chk("wake", 12'hc56, conversion_result_bus);
    $display("hold ends");
  endtask
  task t_fifo;
    int n;
    stall = 1;
    w(40);
    chk("overrun", 12'h001, tap_overrun);
    chk("tap", 12'hc56, tap_data);
    // stop conversion so the drain can empty
    shutdown_request = 1;
    stall = 0;
    for (n = 0; n < 40 && tap_valid !== 0; n++) w(1);
    chk("empty", 12'h000, tap_valid);
    $display("fifo ends");
    if (n == 40) stop_test();
  endtask
  initial
  begin
    w(6);
    rst = 0;
    t_float();
    t_stream();
    t_hold();
    t_fifo();
    stop_test();
  end
endmodule
`default_nettype wire
